// [timer_compare_match_status.sv]
// Eight-bit timer with compare-match flags, pin actions and AXI4-Lite registers
`timescale 1ns/100ps
module timer_compare_match_status
  import timer_match_pkg::*;
#(
  parameter int TICK_DIVIDE = TICK_DIV
)
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Transfer controller service
  input wire logic i_served_a,
  input wire logic i_served_b,
  output logic o_match_a_request,
  output logic o_match_b_request,
  output logic o_wrap_request,
  // Interrupt and pin
  output logic o_irq,
  output logic o_timer_pin,
  output logic o_timer_pin_enable
);

  // ----------------------------------------
  // Bus front end
  // ----------------------------------------
  reg_write_t wr;
  logic wr_go;
  logic rd_go;
  logic [15:0] rd_idx;
  logic wr_hit;
  logic rd_hit;
  logic [7:0] rd_data;

  axil_reg_port u_port (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_awaddr(i_awaddr),
    .i_awvalid(i_awvalid),
    .o_awready(o_awready),
    .i_wdata(i_wdata),
    .i_wstrb(i_wstrb),
    .i_wvalid(i_wvalid),
    .o_wready(o_wready),
    .o_bresp(o_bresp),
    .o_bvalid(o_bvalid),
    .i_bready(i_bready),
    .i_araddr(i_araddr),
    .i_arvalid(i_arvalid),
    .o_arready(o_arready),
    .o_rdata(o_rdata),
    .o_rresp(o_rresp),
    .o_rvalid(o_rvalid),
    .i_rready(i_rready),
    .o_wr(wr),
    .o_wr_go(wr_go),
    .i_wr_hit(wr_hit),
    .o_rd_idx(rd_idx),
    .o_rd_go(rd_go),
    .i_rd_hit(rd_hit),
    .i_rd_data(rd_data)
  );

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] control;
  logic [7:0] const_a;
  logic [7:0] const_b;
  logic [7:0] count_value;
  logic [3:0] pin_select;
  logic [EVENTS-1:0] flags;
  logic [EVENTS-1:0] armed;
  logic [EVENTS-1:0] irq_status;
  logic [EVENTS-1:0] irq_mask;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  function automatic logic known(input logic [15:0] idx);
    known = (idx == IDX_CONTROL) || (idx == IDX_FLAGS) || (idx == IDX_CONST_B) ||
            (idx == IDX_CONST_A) || (idx == IDX_COUNT) || (idx == IDX_IRQ_STATUS) ||
            (idx == IDX_IRQ_MASK);
  endfunction

  // Only byte lane 0 carries the 8-bit registers; other lanes are dropped
  wire lane0 = wr_go & wr.strb[0];
  wire wr_control = lane0 & (wr.idx == IDX_CONTROL);
  wire wr_flags = lane0 & (wr.idx == IDX_FLAGS);
  wire wr_const_b = lane0 & (wr.idx == IDX_CONST_B);
  wire wr_const_a = lane0 & (wr.idx == IDX_CONST_A);
  wire wr_count = lane0 & (wr.idx == IDX_COUNT);
  wire wr_mask = lane0 & (wr.idx == IDX_IRQ_MASK);
  wire rd_flags = rd_go & (rd_idx == IDX_FLAGS);
  wire rd_status = rd_go & (rd_idx == IDX_IRQ_STATUS);
  assign wr_hit = known(wr.idx);
  assign rd_hit = known(rd_idx);

  wire [7:0] flags_view = {flags, 1'b1, pin_select};
  assign rd_data = (rd_idx == IDX_CONTROL) ? control :
                   (rd_idx == IDX_FLAGS) ? flags_view :
                   (rd_idx == IDX_CONST_B) ? const_b :
                   (rd_idx == IDX_CONST_A) ? const_a :
                   (rd_idx == IDX_COUNT) ? count_value :
                   (rd_idx == IDX_IRQ_STATUS) ? {5'h00, irq_status} :
                   (rd_idx == IDX_IRQ_MASK) ? {5'h00, irq_mask} : 8'h00;

  // ----------------------------------------
  // Count tick divider
  // ----------------------------------------
  localparam int DIV_W = (TICK_DIVIDE > 1) ? $clog2(TICK_DIVIDE) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIVIDE - 1);
  logic [DIV_W-1:0] div_count;
  wire count_on = control[BIT_COUNT_ENABLE];
  wire tick = count_on & (div_count == DIV_LAST);

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      div_count <= '0;
    end else if (!count_on || tick) begin
      div_count <= '0;
    end else begin
      div_count <= div_count + 1'b1;
    end
  end

  // ----------------------------------------
  // Counter and compare
  // ----------------------------------------
  // A software write to the count takes the tick's place and raises no event
  wire advance = tick & ~wr_count;
  wire [7:0] next_count = count_value + 8'h01;
  wire hit_a = advance & (next_count == const_a);
  wire hit_b = advance & (next_count == const_b);
  wire hit_wrap = advance & (count_value == COUNT_TOP);
  timer_events_t ev;
  assign ev = '{b: hit_b, a: hit_a, wrap: hit_wrap};

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      count_value <= RESET_COUNT;
    end else if (wr_count) begin
      count_value <= wr.data[7:0];
    end else if (advance) begin
      count_value <= next_count;
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      control <= RESET_CONTROL;
      const_a <= RESET_CONST;
      const_b <= RESET_CONST;
      pin_select <= RESET_PIN_SELECT;
      irq_mask <= '0;
    end else begin
      if (wr_control) control <= wr.data[7:0];
      if (wr_const_a) const_a <= wr.data[7:0];
      if (wr_const_b) const_b <= wr.data[7:0];
      if (wr_flags) pin_select <= wr.data[3:0];
      if (wr_mask) irq_mask <= wr.data[EVENTS-1:0];
    end
  end

  // ----------------------------------------
  // Flags: set by events, cleared by read-1-then-write-0 or, for match A and B only, by service
  // ----------------------------------------
  wire [EVENTS-1:0] set_v = ev;
  wire [EVENTS-1:0] served_v = {i_served_b, i_served_a, 1'b0};
  logic [EVENTS-1:0] next_flags;
  logic [EVENTS-1:0] next_armed;

  genvar gi;
  generate
    for (gi = 0; gi < EVENTS; gi++) begin : g_flag
      // A written 1 is ignored; a 0 clears only a flag that was read as 1
      wire sw_clear = wr_flags & armed[gi] & ~wr.data[BIT_FLAG_LOW+gi];
      assign next_flags[gi] = set_v[gi] | (flags[gi] & ~(sw_clear | served_v[gi]));
      assign next_armed[gi] = rd_flags ? flags[gi] : (armed[gi] & ~wr_flags);
    end
  endgenerate

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      flags <= '0;
      armed <= '0;
    end else begin
      flags <= next_flags;
      armed <= next_armed;
    end
  end

  // ----------------------------------------
  // Interrupt status and requests
  // ----------------------------------------
  // A read clears the status, but an event in that same cycle survives
  wire [EVENTS-1:0] next_status = set_v | (irq_status & {EVENTS{~rd_status}});

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      irq_status <= '0;
      o_irq <= 1'b0;
      o_match_a_request <= 1'b0;
      o_match_b_request <= 1'b0;
      o_wrap_request <= 1'b0;
    end else begin
      irq_status <= next_status;
      o_irq <= |(next_status & irq_mask);
      o_match_a_request <= next_flags[1] & control[BIT_MATCH_A_IRQ_ENABLE];
      o_match_b_request <= next_flags[2] & control[BIT_MATCH_B_IRQ_ENABLE];
      o_wrap_request <= next_flags[0] & control[BIT_WRAP_IRQ_ENABLE];
    end
  end

  // ----------------------------------------
  // Output pin
  // ----------------------------------------
  match_pin_drive u_pin (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_hit_a(hit_a),
    .i_hit_b(hit_b),
    .i_select(pin_select),
    .o_pin(o_timer_pin),
    .o_pin_enable(o_timer_pin_enable)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Each cause is sampled in one cycle and its effect checked at the next edge, except a_irq_level, which checks in the same cycle
  a_b_request_gate: assert property (@(posedge i_mclk) disable iff (i_reset)
    !control[BIT_MATCH_B_IRQ_ENABLE] |=> !o_match_b_request)
    else $error("match B request while disabled");
  a_b_request_pass: assert property (@(posedge i_mclk) disable iff (i_reset)
    (control[BIT_MATCH_B_IRQ_ENABLE] && flags[2] && !i_served_b && !wr_flags)
      |=> o_match_b_request) else $error("enabled match B request missing");
  a_a_request_gate: assert property (@(posedge i_mclk) disable iff (i_reset)
    !control[BIT_MATCH_A_IRQ_ENABLE] |=> !o_match_a_request)
    else $error("match A request while disabled");
  a_a_flag_set: assert property (@(posedge i_mclk) disable iff (i_reset)
    (advance && next_count == const_a) |=> flags[1])
    else $error("match A flag not set");
  a_b_flag_set: assert property (@(posedge i_mclk) disable iff (i_reset)
    (advance && next_count == const_b) |=> flags[2])
    else $error("match B flag not set");
  a_a_served_clear: assert property (@(posedge i_mclk) disable iff (i_reset)
    (flags[1] && i_served_a && !hit_a) |=> !flags[1])
    else $error("served A not cleared");
  a_b_served_clear: assert property (@(posedge i_mclk) disable iff (i_reset)
    (flags[2] && i_served_b && !hit_b) |=> !flags[2])
    else $error("served B not cleared");
  a_b_arm_read: assert property (@(posedge i_mclk) disable iff (i_reset)
    (rd_flags && flags[2]) |=> armed[2])
    else $error("match B flag read as 1 not armed");
  a_b_sw_clear: assert property (@(posedge i_mclk) disable iff (i_reset)
    (wr_flags && armed[2] && !wr.data[BIT_FLAG_LOW+2] && !hit_b) |=> !flags[2])
    else $error("match B read-then-clear failed");
  a_flag_one_write: assert property (@(posedge i_mclk) disable iff (i_reset)
    (wr_flags && wr.data[7:5] == 3'b111 && !i_served_a && !i_served_b)
      |=> flags == ($past(flags) | $past(set_v))) else $error("writing 1 changed a flag");
  a_b_const_load: assert property (@(posedge i_mclk) disable iff (i_reset)
    wr_const_b |=> const_b == $past(wr.data[7:0]))
    else $error("match constant B not written");
  a_count_write: assert property (@(posedge i_mclk) disable iff (i_reset)
    wr_count |=> count_value == $past(wr.data[7:0]))
    else $error("count value not written");
  a_count_hold: assert property (@(posedge i_mclk) disable iff (i_reset)
    (!count_on && !wr_count) |=> $stable(count_value))
    else $error("count moved while stopped");
  a_wrap_flag_set: assert property (@(posedge i_mclk) disable iff (i_reset)
    (advance && count_value == 8'hff) |=> (flags[0] && count_value == 8'h00))
    else $error("wrap flag not set on wrap");
  a_unarmed_keep: assert property (@(posedge i_mclk) disable iff (i_reset)
    (wr_flags && armed == 3'b000 && flags[0]) |=> flags[0])
    else $error("flag cleared without a prior read");
  a_status_read_clear: assert property (@(posedge i_mclk) disable iff (i_reset)
    (rd_status && set_v == 3'b000) |=> irq_status == 3'b000)
    else $error("status not cleared by read");
  a_irq_level: assert property (@(posedge i_mclk) disable iff (i_reset)
    $stable(irq_mask) |-> (o_irq == |(irq_status & irq_mask)))
    else $error("interrupt level wrong");

endmodule // timer_compare_match_status

// [timer_match_pkg.sv]
// Constants, register map and carrier types for the compare-match timer block
package timer_match_pkg;

  // ----------------------------------------
  // Register indices (byte address is index times four)
  // ----------------------------------------
  localparam logic [15:0] IDX_CONTROL = 16'hfed0;
  localparam logic [15:0] IDX_FLAGS = 16'hfed2;
  localparam logic [15:0] IDX_CONST_B = 16'hfed3;
  localparam logic [15:0] IDX_CONST_A = 16'hfed4;
  localparam logic [15:0] IDX_COUNT = 16'hfed5;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'hfed6;
  localparam logic [15:0] IDX_IRQ_MASK = 16'hfed7;
  localparam int ADDR_W = 18;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_MATCH_B_IRQ_ENABLE = 7;
  localparam int BIT_MATCH_A_IRQ_ENABLE = 6;
  localparam int BIT_WRAP_IRQ_ENABLE = 5;
  localparam int BIT_COUNT_ENABLE = 0;
  localparam int BIT_FLAG_LOW = 5;
  localparam int BIT_FLAGS_ONE = 4;
  localparam int EVENTS = 3;

  // ----------------------------------------
  // Reset values and counts
  // ----------------------------------------
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [7:0] RESET_CONST = 8'hff;
  localparam logic [7:0] RESET_COUNT = 8'h00;
  localparam logic [3:0] RESET_PIN_SELECT = 4'h0;
  localparam logic [7:0] COUNT_TOP = 8'hff;
  localparam int TICK_DIV = 8;

  // ----------------------------------------
  // Bus answers and pin actions
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef enum logic [1:0] {
    PIN_KEEP = 2'b00,
    PIN_LOW = 2'b01,
    PIN_HIGH = 2'b10,
    PIN_TOGGLE = 2'b11
  } pin_action_t;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] idx;
    logic [31:0] data;
    logic [3:0] strb;
  } reg_write_t;

  typedef struct packed {
    logic b;
    logic a;
    logic wrap;
  } timer_events_t;

endpackage

// [axil_reg_port.sv]
// AXI4-Lite slave front end that turns bus transfers into register strobes
`timescale 1ns/100ps
module axil_reg_port
  import timer_match_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Write channels
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // Read channels
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Register side
  output reg_write_t o_wr,
  output logic o_wr_go,
  input wire logic i_wr_hit,
  output logic [15:0] o_rd_idx,
  output logic o_rd_go,
  input wire logic i_rd_hit,
  input wire logic [7:0] i_rd_data
);

  logic aw_got;
  logic w_got;
  logic ar_got;
  wire aw_take = i_awvalid & o_awready;
  wire w_take = i_wvalid & o_wready;
  wire ar_take = i_arvalid & o_arready;

  // Both halves of a write must be in hand before the register sees it
  assign o_wr_go = aw_got & w_got & ~o_bvalid;
  assign o_rd_go = ar_got & ~o_rvalid;

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
      o_wr <= '0;
    end else begin
      if (aw_take) begin
        o_awready <= 1'b0;
        aw_got <= 1'b1;
        o_wr.idx <= i_awaddr[ADDR_W-1:2];
      end
      if (w_take) begin
        o_wready <= 1'b0;
        w_got <= 1'b1;
        o_wr.data <= i_wdata;
        o_wr.strb <= i_wstrb;
      end
      if (o_wr_go) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= i_wr_hit ? RESP_OKAY : RESP_DECERR;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_arready <= 1'b1;
      ar_got <= 1'b0;
      o_rvalid <= 1'b0;
      o_rresp <= RESP_OKAY;
      o_rdata <= '0;
      o_rd_idx <= '0;
    end else begin
      if (ar_take) begin
        o_arready <= 1'b0;
        ar_got <= 1'b1;
        o_rd_idx <= i_araddr[ADDR_W-1:2];
      end
      if (o_rd_go) begin
        ar_got <= 1'b0;
        o_rvalid <= 1'b1;
        o_rdata <= {24'h000000, i_rd_data};
        o_rresp <= i_rd_hit ? RESP_OKAY : RESP_DECERR;
      end
      if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end

endmodule // axil_reg_port

// [match_pin_drive.sv]
// Timer output pin driven by compare-match A and B actions
`timescale 1ns/100ps
module match_pin_drive
  import timer_match_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Match events and action select
  input wire logic i_hit_a,
  input wire logic i_hit_b,
  input wire logic [3:0] i_select,
  // Pin
  output logic o_pin,
  output logic o_pin_enable
);

  wire pin_action_t action_a = pin_action_t'(i_select[1:0]);
  wire pin_action_t action_b = pin_action_t'(i_select[3:2]);
  wire out_on = |i_select;

  function automatic logic apply(input pin_action_t act, input logic cur);
    unique case (act)
      PIN_KEEP: apply = cur;
      PIN_LOW: apply = 1'b0;
      PIN_HIGH: apply = 1'b1;
      PIN_TOGGLE: apply = ~cur;
    endcase
  endfunction

  // A coincident match A takes the pin; match B acts only on its own
  wire after_b = i_hit_b ? apply(action_b, o_pin) : o_pin;
  wire next_pin = i_hit_a ? apply(action_a, o_pin) : after_b;

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_pin <= 1'b0;
      o_pin_enable <= 1'b0;
    end else begin
      o_pin_enable <= out_on;
      if (out_on) begin
        o_pin <= next_pin;
      end
    end
  end

  a_pin_idle_hold: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_select == 4'h0) |=> $stable(o_pin)) else $error("pin moved while disabled");
  a_b_toggle_pin: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_hit_b && !i_hit_a && i_select[3:2] == 2'b11) |=> (o_pin != $past(o_pin)))
    else $error("match B toggle missed");
  a_b_low_pin: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_hit_b && !i_hit_a && i_select[3:2] == 2'b01) |=> !o_pin)
    else $error("match B drive low missed");
  a_a_high_pin: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_hit_a && i_select[1:0] == 2'b10) |=> o_pin)
    else $error("match A drive high missed");

endmodule // match_pin_drive

// [pin_load_model.sv]
// External load on the timer output pin, with a pull-up
`timescale 1ns/100ps
module pin_load_model (
  // Timer pin from the block
  input wire logic i_pin,
  input wire logic i_pin_enable,
  // Level seen by the external circuit
  output logic o_line
);
  // ----------------------------------------
  // Line level
  // ----------------------------------------
  // Pull-up holds the line high while the output is disabled, so a stale pin never shows
  assign o_line = i_pin_enable ? i_pin : 1'b1;
endmodule // pin_load_model

// [timer_compare_match_status_tb_top.sv]
// Register-level testbench for the compare-match timer block
`timescale 1ns/100ps
module timer_compare_match_status_tb_top;
  import timer_match_pkg::*;
  logic mclk, reset;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready, served_a, served_b;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic req_a, req_b, req_wrap, irq, pin, pin_en, line;
  logic [7:0] rd;
  int fail_count, total_checks;
  logic [3:0] sel_tab [6] = '{4'h2, 4'h1, 4'h3, 4'h8, 4'h4, 4'hc};

  // ----------------------------------------
  // Design and load
  // ----------------------------------------
  // Short tick keeps a full count period at 256 cycles
  timer_compare_match_status #(.TICK_DIVIDE(1)) i_dut (
    .i_mclk(mclk), .i_reset(reset),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_served_a(served_a), .i_served_b(served_b),
    .o_match_a_request(req_a), .o_match_b_request(req_b), .o_wrap_request(req_wrap),
    .o_irq(irq), .o_timer_pin(pin), .o_timer_pin_enable(pin_en)
  );
  pin_load_model i_load (.i_pin(pin), .i_pin_enable(pin_en), .o_line(line));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ----------------------------------------
  // Checks and ending
  // ----------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic fail_wait;
    chk_bit(1'b0, 1'b1);
    stop_test;
  endtask

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    int n;
    logic awp, wp;
    @(posedge mclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    awp = 1'b1;
    wp = 1'b1;
    n = 0;
    while (awp || wp) begin
      @(posedge mclk);
      if (awp && awready === 1'b1) begin
        awvalid <= 1'b0;
        awp = 1'b0;
      end
      if (wp && wready === 1'b1) begin
        wvalid <= 1'b0;
        wp = 1'b0;
      end
      n++;
      if (n > 50) fail_wait;
    end
    while (bvalid !== 1'b1) begin
      @(posedge mclk);
      n++;
      if (n > 100) fail_wait;
    end
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [15:0] idx);
    int n;
    @(posedge mclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (n > 50) fail_wait;
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) begin
      @(posedge mclk);
      n++;
      if (n > 100) fail_wait;
    end
    rd = rdata[7:0];
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic wait_flags(input logic [7:0] m);
    int n;
    for (n = 0; n < 200; n++) begin
      rd_reg(IDX_FLAGS);
      if ((rd & m) === m) return;
    end
    fail_wait;
  endtask

  // Count keeps running, so each action shows within one period
  task automatic wait_pin(input logic exp);
    int n;
    for (n = 0; n < 700; n++) begin
      @(posedge mclk);
      #1;
      if (pin === exp) break;
    end
    chk_bit(pin, exp);
    if (pin !== exp) stop_test;
  endtask

  task automatic settle;
    @(posedge mclk);
    #1;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready, served_a, served_b} = '0;
    fail_count = 0;
    total_checks = 0;
    reset = 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rd_reg(IDX_CONST_B);
    chk_val(rd, 8'hff);
    rd_reg(IDX_FLAGS);
    chk_val(rd, 8'h10);
    chk_bit(pin_en, 1'b0);
    wr(IDX_CONST_B, 8'h5a);
    chk_val({6'h0, resp}, {6'h0, RESP_OKAY});
    rd_reg(IDX_CONST_B);
    chk_val(rd, 8'h5a);
    rd_reg(16'hfed1);
    chk_val({6'h0, resp}, {6'h0, RESP_DECERR});
    chk_val(rd, 8'h00);
    wr(16'hfed1, 8'h55);
    chk_val({6'h0, resp}, {6'h0, RESP_DECERR});
    $display("test registers done");
    wr(IDX_CONST_A, 8'h10);
    wr(IDX_CONST_B, 8'h20);
    wr(IDX_CONTROL, 8'h01);
    wait_flags(8'he0);
    wr(IDX_CONTROL, 8'h00);
    settle;
    chk_bit(irq, 1'b0);
    rd_reg(IDX_FLAGS);
    chk_val(rd, 8'hf0);
    chk_bit(req_b, 1'b0);
    wr(IDX_IRQ_MASK, 8'h07);
    settle;
    chk_bit(irq, 1'b1);
    rd_reg(IDX_IRQ_STATUS);
    chk_val(rd, 8'h07);
    settle;
    chk_bit(irq, 1'b0);
    wr(IDX_CONTROL, 8'h80);
    settle;
    chk_bit(req_b, 1'b1);
    chk_bit(req_a, 1'b0);
    chk_bit(req_wrap, 1'b0);
    wr(IDX_CONTROL, 8'h20);
    settle;
    chk_bit(req_wrap, 1'b1);
    chk_bit(req_b, 1'b0);
    wr(IDX_CONTROL, 8'h00);
    settle;
    chk_bit(req_b, 1'b0);
    chk_bit(req_wrap, 1'b0);
    $display("test events done");
    // A write disarms, so the bare clear that follows must be ignored
    wr(IDX_FLAGS, 8'he0);
    wr(IDX_FLAGS, 8'h00);
    rd_reg(IDX_FLAGS);
    chk_val(rd, 8'hf0);
    wr(IDX_FLAGS, 8'h60);
    rd_reg(IDX_FLAGS);
    chk_val(rd, 8'h70);
    wr(IDX_FLAGS, 8'h00);
    rd_reg(IDX_FLAGS);
    chk_val(rd, 8'h10);
    $display("test flag clearing done");
    wr(IDX_CONTROL, 8'h01);
    wait_flags(8'hc0);
    wr(IDX_CONTROL, 8'hc0);
    settle;
    chk_bit(req_a, 1'b1);
    @(posedge mclk);
    served_a <= 1'b1;
    @(posedge mclk);
    served_a <= 1'b0;
    #1;
    chk_bit(req_a, 1'b0);
    chk_bit(req_b, 1'b1);
    @(posedge mclk);
    served_b <= 1'b1;
    @(posedge mclk);
    served_b <= 1'b0;
    #1;
    chk_bit(req_b, 1'b0);
    rd_reg(IDX_FLAGS);
    chk_val(rd & 8'hc0, 8'h00);
    $display("test transfer service done");
    wr(IDX_CONTROL, 8'h01);
    repeat (300) @(posedge mclk);
    #1;
    chk_bit(pin, 1'b0);
    chk_bit(line, 1'b1);
    for (int i = 0; i < 6; i++) begin
      wr(IDX_FLAGS, {4'h0, sel_tab[i]});
      wait_pin(sel_tab[i] != 4'h1 && sel_tab[i] != 4'h4);
      if (sel_tab[i] == 4'h3 || sel_tab[i] == 4'hc) wait_pin(1'b0);
      chk_bit(pin_en, 1'b1);
      chk_bit(line, pin);
    end
    wr(IDX_FLAGS, 8'h00);
    settle;
    settle;
    chk_bit(pin_en, 1'b0);
    chk_bit(line, 1'b1);
    $display("test pin actions done");
    stop_test;
  end
endmodule // timer_compare_match_status_tb_top
